// ===== src/aos_pkg.sv
// aos_pkg: constants and carrier types for the one-shot converter sequencer.
// assumes a single 20 MHz clock domain and a synchronous active-high reset.
// Function
// - external-trigger mode starts a conversion on a trigger falling edge while start flag is 1.
// - triggered completion copies the approximation result into the channel result and raises the request.
// - after a triggered conversion the converter halts until the next falling edge.
// - each later falling edge while idle starts a whole new conversion.
// - a falling edge during conversion abandons it and restarts from step one.
// - expansion mode start flag write converts the selected expansion input.
// - expansion mode completion stores result, sets request, clears start flag, stops.
// - with sample-and-hold a conversion takes 28 cycles at 8 bits, 33 at 10.
// - request bit stays set until accepted or cleared by software.
// - below 1MHz no sample-and-hold; 8-bit conversion takes 49 cycles.
// - op-amp mode start routes the selected normal channel to the expansion output.
// - op-amp mode converts the expansion return pin; board supplies the amplifier.
// - op-amp mode result goes to the selected normal channel's register, then request raised.
// - conversion clock is base clock divided by 4, by 2, or undivided.
// - sample-and-hold samples the input for 3 conversion-clock cycles first.
`default_nettype none

package aos_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned RES_W = 10;
  // conversion-clock cycles per conversion
  localparam logic [5:0] CYC_SH_8 = 6'h1c;   // 28
  localparam logic [5:0] CYC_SH_10 = 6'h21;  // 33
  localparam logic [5:0] CYC_NSH_8 = 6'h31;  // 49
  localparam logic [5:0] CYC_NSH_10 = 6'h3b; // 59
  localparam logic [5:0] CYC_SAMPLE = 6'h03;
  localparam int unsigned SH_MIN_HZ = 1_000_000;
  // divider select codes
  localparam logic [1:0] DIV_4 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_1 = 2'h2;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [1:0] DIV2_LAST = 2'h1;

  typedef enum logic [1:0] {
    AOS_MODE_SOFT,
    AOS_MODE_EXT_TRIG,
    AOS_MODE_EXPANSION,
    AOS_MODE_OPAMP
  } aos_mode_t;

  typedef struct packed {
    aos_mode_t mode;
    logic [1:0] clk_div;
    logic res_10bit;
    logic sample_hold;
    logic [2:0] selected_normal_channel;
    logic selected_expansion_input;
  } aos_cfg_t;

  typedef struct packed {
    logic [2:0] channel;
    logic [RES_W-1:0] value;
  } aos_result_t;
endpackage

`default_nettype wire

// ===== src/aos_clk_div.sv
// aos_clk_div: conversion-clock enable pulse generator.
// assumes the select input is stable while a conversion runs.
`default_nettype none

module aos_clk_div (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // control
  input wire logic [1:0] div_sel,
  input wire logic restart,
  // conversion-clock tick
  output logic tick_ff
);
  logic [1:0] cnt_ff;
  logic [1:0] last;

  // ============================================================
  // divider
  always_comb begin
    case (div_sel)
      aos_pkg::DIV_4: last = aos_pkg::DIV4_LAST;
      aos_pkg::DIV_2: last = aos_pkg::DIV2_LAST;
      default: last = 2'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_ff <= 2'h0;
      tick_ff <= 1'b0;
    end else if (restart) begin
      // first tick one full period after a start, else the sample phase runs one cycle long
      cnt_ff <= (last == 2'h0) ? 2'h0 : 2'h1;
      tick_ff <= (last == 2'h0);
    end else begin
      tick_ff <= (cnt_ff == last);
      cnt_ff <= (cnt_ff == last) ? 2'h0 : cnt_ff + 2'h1;
    end
  end
endmodule

`default_nettype wire

// ===== src/aos_sequencer.sv
// aos_sequencer: one-shot successive-approximation converter sequencer.
// assumes the comparator is external and trigger input is synchronous to ref_clk.
`default_nettype none

module aos_sequencer #(
  parameter int unsigned RES_W = aos_pkg::RES_W,
  parameter int unsigned NUM_CH = aos_pkg::NUM_CH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // configuration
  input wire aos_pkg::aos_cfg_t cfg,
  // software control
  input wire logic start_set,
  input wire logic start_clr,
  input wire logic irq_clr,
  // link pins
  input wire logic ext_conv_trigger_pin,
  // comparator: 1 when sampled input is above dac trial value
  input wire logic cmp_above,
  // analog routing controls
  output logic [2:0] mux_sel_ff,
  output logic mux_expansion_ff,
  output logic expansion_out_pin_en_ff,
  output logic sample_ff,
  output logic [RES_W-1:0] dac_trial_ff,
  // status
  output logic start_flag_ff,
  output logic busy_ff,
  output logic irq_req_ff,
  output logic result_valid_ff,
  output aos_pkg::aos_result_t result_ff,
  output logic [NUM_CH*RES_W-1:0] ch_results_ff
);
  typedef enum logic [1:0] {
    AOS_ST_IDLE,
    AOS_ST_SAMPLE,
    AOS_ST_CONVERT,
    AOS_ST_HALT
  } aos_state_t;

  aos_state_t state_ff;
  logic trig_prev_ff;
  logic trig_fall;
  logic tick;
  logic start_ff;
  logic go;
  logic restart;
  logic done;
  logic [5:0] cyc_ff;
  logic [5:0] cyc_total;
  logic [3:0] bit_ff;
  logic [RES_W-1:0] sar_ff;
  logic [RES_W-1:0] res_final;
  logic [RES_W-1:0] mem_ff [NUM_CH];
  logic ext_mode;

  // ============================================================
  // trigger edge and start decision
  assign ext_mode = (cfg.mode == aos_pkg::AOS_MODE_EXT_TRIG);
  assign trig_fall = trig_prev_ff && !ext_conv_trigger_pin;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trig_prev_ff <= 1'b1;
      start_ff <= 1'b0;
    end else begin
      trig_prev_ff <= ext_conv_trigger_pin;
      start_ff <= start_set && !start_flag_ff;
    end
  end

  // a falling edge in any state restarts; idle or mid-conversion alike
  assign go = ext_mode ? (trig_fall && start_flag_ff)
                       : (start_ff && start_flag_ff);
  assign restart = go;

  aos_clk_div u_div (
    .ref_clk(ref_clk),
    .srst(srst),
    .div_sel(cfg.clk_div),
    .restart(restart),
    .tick_ff(tick)
  );

  // ============================================================
  // cycle budget
  always_comb begin
    if (cfg.sample_hold) begin
      cyc_total = cfg.res_10bit ? aos_pkg::CYC_SH_10 : aos_pkg::CYC_SH_8;
    end else begin
      cyc_total = cfg.res_10bit ? aos_pkg::CYC_NSH_10 : aos_pkg::CYC_NSH_8;
    end
  end

  // 8-bit mode converts all bits but keeps only the upper bits of the word
  assign res_final = cfg.res_10bit ? sar_ff : {sar_ff[RES_W-1:2], 2'h0};
  assign done = (state_ff == AOS_ST_CONVERT) && tick && (cyc_ff == cyc_total - 6'h01);

  // ============================================================
  // state machine and cycle counter
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff <= AOS_ST_IDLE;
      cyc_ff <= 6'h00;
    end else if (restart) begin
      cyc_ff <= 6'h00;
      state_ff <= cfg.sample_hold ? AOS_ST_SAMPLE : AOS_ST_CONVERT;
    end else if (tick) begin
      case (state_ff)
        AOS_ST_SAMPLE: begin
          cyc_ff <= cyc_ff + 6'h01;
          if (cyc_ff == aos_pkg::CYC_SAMPLE - 6'h01) begin
            state_ff <= AOS_ST_CONVERT;
          end
        end
        AOS_ST_CONVERT: begin
          cyc_ff <= cyc_ff + 6'h01;
          if (done) begin
            state_ff <= ext_mode ? AOS_ST_HALT : AOS_ST_IDLE;
          end
        end
        AOS_ST_HALT: state_ff <= AOS_ST_HALT;
        AOS_ST_IDLE: state_ff <= AOS_ST_IDLE;
        default: state_ff <= AOS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_ff <= 1'b0;
      sample_ff <= 1'b0;
    end else begin
      busy_ff <= restart || (state_ff == AOS_ST_SAMPLE) || (state_ff == AOS_ST_CONVERT && !done);
      sample_ff <= restart ? cfg.sample_hold : (state_ff == AOS_ST_SAMPLE && !(tick &&
                   cyc_ff == aos_pkg::CYC_SAMPLE - 6'h01));
    end
  end

  // ============================================================
  // successive approximation, one bit per conversion-clock tick from msb
  always_ff @(posedge ref_clk) begin
    if (srst || restart) begin
      sar_ff <= '0;
      dac_trial_ff <= {1'b1, {(RES_W-1){1'b0}}};
      bit_ff <= 4'(RES_W - 1);
    end else if (tick && state_ff == AOS_ST_CONVERT && bit_ff != 4'hf) begin
      sar_ff[bit_ff] <= cmp_above;
      if (bit_ff != 4'h0) begin
        dac_trial_ff <= dac_trial_ff | ({{(RES_W-1){1'b0}}, 1'b1} << (bit_ff - 4'h1));
        if (!cmp_above) begin
          dac_trial_ff[bit_ff] <= 1'b0;
        end
      end
      bit_ff <= bit_ff - 4'h1;
    end
  end

  // ============================================================
  // input routing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mux_sel_ff <= 3'h0;
      mux_expansion_ff <= 1'b0;
      expansion_out_pin_en_ff <= 1'b0;
    end else begin
      mux_sel_ff <= cfg.selected_normal_channel;
      // op-amp mode converts the return pin, expansion mode the chosen pin
      mux_expansion_ff <= (cfg.mode == aos_pkg::AOS_MODE_EXPANSION) ||
                          (cfg.mode == aos_pkg::AOS_MODE_OPAMP);
      expansion_out_pin_en_ff <= (cfg.mode == aos_pkg::AOS_MODE_OPAMP) && start_flag_ff;
    end
  end

  // ============================================================
  // start flag
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      start_flag_ff <= 1'b0;
    end else if (start_set) begin
      start_flag_ff <= 1'b1;
    end else if (start_clr) begin
      start_flag_ff <= 1'b0;
    end else if (done && !ext_mode) begin
      start_flag_ff <= 1'b0;
    end
    // external-trigger mode keeps the flag so later edges stay armed
  end

  // ============================================================
  // results and request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      result_ff <= '0;
      result_valid_ff <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        mem_ff[i] <= '0;
      end
    end else begin
      result_valid_ff <= done;
      if (done) begin
        // op-amp result lands in the normal channel's slot
        mem_ff[cfg.selected_normal_channel] <= res_final;
        result_ff.channel <= cfg.selected_normal_channel;
        result_ff.value <= res_final;
      end
    end
  end

  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_res
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          ch_results_ff[g*RES_W +: RES_W] <= '0;
        end else begin
          ch_results_ff[g*RES_W +: RES_W] <= (done && cfg.selected_normal_channel == 3'(g)) ? res_final : mem_ff[g];
        end
      end
    end
  endgenerate

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_req_ff <= 1'b0;
    end else if (done) begin
      irq_req_ff <= 1'b1;
    end else if (irq_clr) begin
      irq_req_ff <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== verification/aos_checker.sv
// aos_checker: port-level assertions for aos_sequencer.
// assumes cfg stays stable while a conversion runs.
`default_nettype none

module aos_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // inputs
  input wire aos_pkg::aos_cfg_t cfg,
  input wire logic irq_clr,
  input wire logic ext_conv_trigger_pin,
  // outputs
  input wire logic expansion_out_pin_en_ff,
  input wire logic mux_expansion_ff,
  input wire logic sample_ff,
  input wire logic start_flag_ff,
  input wire logic busy_ff,
  input wire logic irq_req_ff,
  input wire logic result_valid_ff,
  input wire aos_pkg::aos_result_t result_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // properties
  logic ext, opa, exm;
  assign ext = cfg.mode == aos_pkg::AOS_MODE_EXT_TRIG;
  assign opa = cfg.mode == aos_pkg::AOS_MODE_OPAMP;
  assign exm = cfg.mode == aos_pkg::AOS_MODE_EXPANSION;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  irq_hold_a: assert property (irq_req_ff && !irq_clr |=> irq_req_ff)
    else $error("irq dropped");
  irq_rise_a: assert property ($rose(irq_req_ff) |-> result_valid_ff)
    else $error("irq without result");
  exp_stop_a: assert property (result_valid_ff && exm |-> !start_flag_ff)
    else $error("flag kept");
  trig_arm_a: assert property (result_valid_ff && ext |-> start_flag_ff)
    else $error("flag lost");
  trig_go_a: assert property ($fell(ext_conv_trigger_pin) && ext && start_flag_ff
    && cfg.sample_hold |-> ##[1:3] sample_ff) else $error("no start on edge");
  // three quiet edges rule out a start still in flight
  idle_stay_a: assert property ((ext && !busy_ff && $stable(ext_conv_trigger_pin)) [*3]
    |=> !busy_ff) else $error("start without edge");
  samp_len_a: assert property ($rose(sample_ff) && cfg.clk_div == aos_pkg::DIV_1
    |-> sample_ff [*3] ##1 !sample_ff) else $error("sample length");
  opa_route_a: assert property (busy_ff && opa |-> expansion_out_pin_en_ff && mux_expansion_ff)
    else $error("no routing");
  res_chan_a: assert property (result_valid_ff && !exm
    |-> result_ff.channel == cfg.selected_normal_channel) else $error("wrong channel");
  restart_c: cover property (ext && busy_ff && $fell(ext_conv_trigger_pin));
  opamp_c: cover property (result_valid_ff && opa);
  exp_c: cover property (result_valid_ff && exm);
endmodule

bind aos_sequencer aos_checker u_chk (
  .ref_clk(ref_clk),
  .srst(srst),
  .cfg(cfg),
  .irq_clr(irq_clr),
  .ext_conv_trigger_pin(ext_conv_trigger_pin),
  .expansion_out_pin_en_ff(expansion_out_pin_en_ff),
  .mux_expansion_ff(mux_expansion_ff),
  .sample_ff(sample_ff),
  .start_flag_ff(start_flag_ff),
  .busy_ff(busy_ff),
  .irq_req_ff(irq_req_ff),
  .result_valid_ff(result_valid_ff),
  .result_ff(result_ff)
);

`default_nettype wire

// ===== verification/aos_partner.sv
// aos_partner: trigger source and analog levels behind the converter.
// assumes fire comes from the bench; the pin idles high.
`default_nettype none

module aos_partner (
  // from bench
  input wire logic fire,
  input wire logic exp_sel,
  // from converter
  input wire logic [2:0] mux_sel,
  input wire logic mux_exp,
  input wire logic out_en,
  input wire logic [9:0] trial,
  // to converter
  output logic cmp_above,
  output logic trig_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // analog side
  logic [9:0] code;
  function automatic logic [9:0] lvl(input logic [3:0] i);
    return i[3] ? (i[0] ? 10'h31a : 10'h0c4) : {i[2:0], 7'h2b};
  endfunction
  always_comb begin
    code = lvl({1'b0, mux_sel});
    if (out_en) code = {code[8:0], 1'b0}; // board amplifier, gain two
    else if (mux_exp) code = lvl({3'h4, exp_sel});
  end
  // half a step above the code, so no trial ever ties
  assign cmp_above = {code, 1'b1} > {trial, 1'b0};
  assign trig_pin = !fire;
endmodule

`default_nettype wire

// ===== verification/tb_top.sv
// tb_top: directed scenarios for the one-shot sequencer.
// assumes aos_partner stands in for trigger and analog pins.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // signals
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  aos_pkg::aos_cfg_t cfg = '0;
  logic start_set = 1'b0;
  logic start_clr = 1'b0;
  logic irq_clr = 1'b0;
  logic fire = 1'b0;
  logic trig, cmp, mexp, oen, smp, flag, busy, irq, rv;
  logic [2:0] msel;
  logic [9:0] trial;
  aos_pkg::aos_result_t res;
  logic [79:0] chr;
  int n_mismatch = 0;
  int n_tests = 0;
  always #25 ref_clk = ~ref_clk;
  aos_sequencer u_dut (.ref_clk(ref_clk), .srst(srst), .cfg(cfg), .start_set(start_set),
    .start_clr(start_clr), .irq_clr(irq_clr), .ext_conv_trigger_pin(trig), .cmp_above(cmp),
    .mux_sel_ff(msel), .mux_expansion_ff(mexp), .expansion_out_pin_en_ff(oen), .sample_ff(smp),
    .dac_trial_ff(trial), .start_flag_ff(flag), .busy_ff(busy), .irq_req_ff(irq),
    .result_valid_ff(rv), .result_ff(res), .ch_results_ff(chr));
  aos_partner u_par (.fire(fire), .exp_sel(cfg.selected_expansion_input), .mux_sel(msel),
    .mux_exp(mexp), .out_en(oen), .trial(trial), .cmp_above(cmp), .trig_pin(trig));
  // =====
  // helpers
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
  endtask
  // stops at the result pulse, so callers judge outputs in that cycle
  task automatic run(input int n, input int d);
    int b;
    int k;
    b = 0;
    for (k = 0; rv !== 1'b1 && k < 400; k++) begin
      @(negedge ref_clk);
      b += int'(busy === 1'b1);
    end
    chk("result_pulse", rv, 1'b1);
    chk("busy_len", 32'(n * d - 3 <= b && b <= n * d + d + 2), 32'h1);
  endtask
  // =====
  // scenarios
  task automatic t_exp();
    cfg = '{aos_pkg::AOS_MODE_EXPANSION, aos_pkg::DIV_1, 1'b1, 1'b1, 3'h2, 1'b1};
    pulse(start_set);
    cyc(1);
    chk("sampling", smp, 1'b1);
    run(33, 1);
    chk("exp_val", 32'(res.value), 32'(u_par.lvl(4'h9)));
    chk("exp_done", {irq, flag}, 2'h2);
    cyc(5);
    chk("irq_kept", irq, 1'b1);
    pulse(irq_clr);
    chk("irq_clr", irq, 1'b0);
    $display("t_exp done");
  endtask
  task automatic t_trig();
    cfg = '{aos_pkg::AOS_MODE_EXT_TRIG, aos_pkg::DIV_2, 1'b0, 1'b1, 3'h5, 1'b0};
    pulse(start_set);
    cyc(10);
    chk("armed", {busy, flag}, 2'h1);
    pulse(fire);
    run(28, 2);
    chk("trig_val", 32'(chr[59:50]), 32'(u_par.lvl(4'h5) & 10'h3fc));
    chk("trig_done", {irq, flag}, 2'h3);
    cyc(20);
    chk("halted", busy, 1'b0);
    pulse(fire);
    cyc(20);
    chk("rerun", busy, 1'b1);
    pulse(fire);
    run(28, 2);
    pulse(start_clr);
    pulse(fire);
    cyc(5);
    chk("disarmed", busy, 1'b0);
    pulse(irq_clr);
    $display("t_trig done");
  endtask
  task automatic t_opa();
    cfg = '{aos_pkg::AOS_MODE_OPAMP, aos_pkg::DIV_4, 1'b1, 1'b1, 3'h3, 1'b0};
    pulse(start_set);
    cyc(2);
    chk("route", {msel, oen, mexp}, 5'h0f);
    run(33, 4);
    chk("opa_val", 32'(chr[39:30]), 32'({u_par.lvl(4'h3), 1'b0}));
    chk("opa_chan", {res.channel, irq}, 4'h7);
    pulse(irq_clr);
    $display("t_opa done");
  endtask
  task automatic t_nsh();
    cfg = '{aos_pkg::AOS_MODE_SOFT, aos_pkg::DIV_4, 1'b0, 1'b0, 3'h6, 1'b0};
    pulse(start_set);
    cyc(1);
    chk("no_sample", smp, 1'b0);
    run(49, 4);
    chk("nsh_val", 32'(chr[69:60]), 32'(u_par.lvl(4'h6) & 10'h3fc));
    $display("t_nsh done");
  endtask
  initial begin
    cyc(4);
    srst = 1'b0;
    t_exp();
    t_trig();
    t_opa();
    t_nsh();
    final_report();
  end
  // the run needs under 1000 cycles
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule

`default_nettype wire
